// file: hdl/hrxf_top.sv
// receive hdlc fifo read-out with status latches and interrupt gating
// Summary of operation
// - fifo overflow sets latched bit 7
// - packet end written sets latched bit 4
// - packet start written sets latched bit 3
// - full rising edge sets latched bit 2
// - available rising edge sets latched bit 0
// - irq needs flag, enable, port enable
// - upper byte read advances fifo
// - lower byte shows status of next data
// - fifo byte sits in bits 15:8
// - reorder picks first bit lsb or msb
// - codes: 000 middle, 001 start
// - end codes 100 good to 111 abort
// - valid bit 0 low when fifo empty
// - live full high only when full
// - available when count reaches threshold groups
`timescale 1ns/1ps
module hrxf_top #(
	parameter int AW = hrxf_pkg::FIFO_AW
) (
	input wire logic clock,
	input wire logic reset_n,
	// host register port, 16-bit with byte lanes
	input wire logic [7:0] host_addr,
	input wire logic host_rd,
	input wire logic host_wr,
	input wire logic [1:0] host_be,
	input wire logic [15:0] host_wdata,
	output logic [15:0] host_rdata,
	// byte stream from the deframer, in arrival bit order
	input wire logic rx_valid,
	output logic rx_ready,
	input wire logic [7:0] rx_byte,
	input wire logic [2:0] rx_code,
	// global per-port interrupt enable
	input wire logic port_global_irq_en,
	output logic irq
);
	localparam int W = 11;
	typedef enum logic [1:0] {
		HRXF_IDLE = 2'b00,
		HRXF_LOAD = 2'b01,
		HRXF_SHOW = 2'b11
	} hrxf_state_t;

	// ==========================================================
	// registers
	logic [15:0] ctrl_ff;
	logic [15:0] latch_ff;
	logic [15:0] irqen_ff;
	logic full_prev_ff;
	logic avail_prev_ff;
	logic [7:0] fifo_byte_ff;
	logic [2:0] packet_state_code_ff;
	logic byte_valid_ff;
	logic [15:0] rdata_ff;
	hrxf_state_t state_ff;
	hrxf_state_t nxt_state;

	// ==========================================================
	// address decode and access strobes
	wire sel_ctrl = (host_addr == hrxf_pkg::OFF_CTRL);
	wire sel_live = (host_addr == hrxf_pkg::OFF_LIVE);
	wire sel_latch = (host_addr == hrxf_pkg::OFF_LATCH);
	wire sel_irqen = (host_addr == hrxf_pkg::OFF_IRQEN);
	wire sel_data = (host_addr == hrxf_pkg::OFF_DATA);
	wire [15:0] lane_mask = {{8{host_be[1]}}, {8{host_be[0]}}};
	wire [15:0] wmask = host_wdata & lane_mask;
	// only an upper-byte read of the data word pops an entry
	wire upper_read = host_rd && sel_data && host_be[1];

	// ==========================================================
	// skid buffer in front of the fifo so a stall drops nothing
	wire [W-1:0] skid_out;
	wire skid_valid;
	wire skid_ready;
	wire reorder = ctrl_ff[hrxf_pkg::CTRL_REORDER];
	wire flush = ctrl_ff[hrxf_pkg::CTRL_FIFO_RST];
	// with reordering the first bit ends in the msb
	wire [7:0] rx_mirror = {rx_byte[0], rx_byte[1], rx_byte[2], rx_byte[3],
		rx_byte[4], rx_byte[5], rx_byte[6], rx_byte[7]};
	wire [7:0] rx_ordered = reorder ? rx_mirror : rx_byte;

	hrxf_skid #(.WIDTH(W)) u_skid (
		.clock(clock),
		.reset_n(reset_n),
		.in_valid(rx_valid && !flush),
		.in_ready(rx_ready),
		.in_data({rx_code, rx_ordered}),
		.out_valid(skid_valid),
		.out_ready(skid_ready),
		.out_data(skid_out)
	);

	// ==========================================================
	// receive fifo
	wire [W-1:0] fifo_out;
	wire [AW:0] fifo_count;
	wire fifo_ovf;
	wire fifo_rd;
	localparam logic [AW:0] DEPTH = (AW+1)'(1 << AW);
	wire fifo_full_live = (fifo_count == DEPTH);
	wire fifo_empty = (fifo_count == '0);
	// the skid stalls while full; overflow is flagged every cycle a word waits, and nothing is lost
	assign skid_ready = !fifo_full_live || flush;
	wire wr_en = skid_valid && !flush;

	hrxf_fifo #(.WIDTH(W), .AW(AW)) u_fifo (
		.clock(clock),
		.reset_n(reset_n),
		.flush(flush),
		.wr_en(wr_en),
		.wr_data(skid_out),
		.rd_en(fifo_rd),
		.rd_data(fifo_out),
		.count(fifo_count),
		.overflow(fifo_ovf)
	);

	// threshold in groups of eight bytes, 8 groups after reset; flush forces available low
	wire [AW+1:0] thr_bytes = (AW+2)'({ctrl_ff[12:8], 3'h0});
	wire data_avail_live = !flush && ({1'b0, fifo_count} >= thr_bytes);

	// ==========================================================
	// event detection
	wire wr_take = wr_en && !fifo_full_live;
	wire [2:0] wr_code = skid_out[10:8];
	wire ev_start = wr_take && (wr_code == hrxf_pkg::PS_START);
	wire ev_end = wr_take && wr_code[2];
	wire ev_full = fifo_full_live && !full_prev_ff;
	wire ev_avail = data_avail_live && !avail_prev_ff;
	// overflow: a word presented at a full fifo is flagged and held in the skid
	wire ev_ovf = fifo_ovf || (skid_valid && fifo_full_live && !flush);
	wire [15:0] ev_vec = {8'h00, ev_ovf, 2'b00, ev_end, ev_start, ev_full,
		1'b0, ev_avail};
	wire [15:0] w1c = (host_wr && sel_latch) ? wmask : 16'h0000;
	// set beats clear when both land in one cycle
	wire [15:0] nxt_latch = ((latch_ff & ~w1c) | ev_vec) & hrxf_pkg::EVENT_MASK;

	// interrupt: flag and enable and port enable
	assign irq = port_global_irq_en && |(latch_ff & irqen_ff);

	// ==========================================================
	// presentation state machine: load the head entry into the word
	// an empty fifo is never popped
	assign fifo_rd = (state_ff == HRXF_SHOW) && upper_read && !fifo_empty;
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			HRXF_IDLE: if (!fifo_empty && !flush) nxt_state = HRXF_LOAD;
			HRXF_LOAD: nxt_state = HRXF_SHOW;
			HRXF_SHOW: if (flush || upper_read) nxt_state = HRXF_IDLE;
			default: nxt_state = HRXF_IDLE;
		endcase
	end

	always_ff @(posedge clock) begin
		if (!reset_n)
			state_ff <= HRXF_IDLE;
		else
			state_ff <= nxt_state;
	end

	// presented byte, code and valid; refreshed only on load, upper read or flush
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			fifo_byte_ff <= 8'h00;
			packet_state_code_ff <= hrxf_pkg::PS_MIDDLE;
			byte_valid_ff <= 1'b0;
		end else if (state_ff == HRXF_LOAD) begin
			fifo_byte_ff <= fifo_out[7:0];
			packet_state_code_ff <= fifo_out[10:8];
			byte_valid_ff <= 1'b1;
		end else if (flush || (upper_read && state_ff == HRXF_SHOW)) begin
			byte_valid_ff <= 1'b0;
		end
	end

	// ==========================================================
	// control, enables and latches
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			ctrl_ff <= hrxf_pkg::CTRL_RESET;
			irqen_ff <= hrxf_pkg::IRQEN_RESET;
			latch_ff <= 16'h0000;
			full_prev_ff <= 1'b0;
			avail_prev_ff <= 1'b0;
		end else begin
			if (host_wr && sel_ctrl)
				ctrl_ff <= ((ctrl_ff & ~lane_mask) | wmask) & hrxf_pkg::CTRL_MASK;
			if (host_wr && sel_irqen)
				irqen_ff <= ((irqen_ff & ~lane_mask) | wmask) & hrxf_pkg::EVENT_MASK;
			latch_ff <= nxt_latch;
			full_prev_ff <= fifo_full_live;
			avail_prev_ff <= data_avail_live;
		end
	end

	// ==========================================================
	// read mux; lower byte shows the status of the byte above
	wire [15:0] live_word = {13'h0000, fifo_full_live, fifo_empty, data_avail_live};
	wire [15:0] data_word = {fifo_byte_ff, 4'h0, packet_state_code_ff, byte_valid_ff};
	wire [15:0] rd_mux = sel_ctrl ? ctrl_ff :
		sel_live ? live_word :
		sel_latch ? latch_ff :
		sel_irqen ? irqen_ff :
		sel_data ? data_word : 16'h0000;

	// read data registered; unmapped addresses read zero
	always_ff @(posedge clock) begin
		if (!reset_n)
			rdata_ff <= 16'h0000;
		else if (host_rd)
			rdata_ff <= rd_mux & lane_mask;
	end
	assign host_rdata = rdata_ff;
endmodule // hrxf_top

// file: hdl/hrxf_pkg.sv
// package of register offsets, field positions, reset values and fifo geometry
package hrxf_pkg;
	// ==========================================================
	// register map, byte offsets on the host bus
	localparam logic [7:0] OFF_CTRL = 8'hB0;
	localparam logic [7:0] OFF_LIVE = 8'hB4;
	localparam logic [7:0] OFF_LATCH = 8'hB6;
	localparam logic [7:0] OFF_IRQEN = 8'hB8;
	localparam logic [7:0] OFF_DATA = 8'hBC;
	// ==========================================================
	// event bit positions, shared by latched flags and enables
	localparam int BIT_OVF = 7;
	localparam int BIT_PEND = 4;
	localparam int BIT_PSTART = 3;
	localparam int BIT_FULL = 2;
	localparam int BIT_AVAIL = 0;
	localparam logic [15:0] EVENT_MASK = 16'h009D;
	// ==========================================================
	// control register fields and reset value
	localparam int CTRL_REORDER = 3;
	localparam int CTRL_FIFO_RST = 0;
	localparam int CTRL_THR_LO = 8;
	localparam logic [15:0] CTRL_RESET = 16'h0800;
	localparam logic [15:0] CTRL_MASK = 16'h1F09;
	localparam logic [15:0] IRQEN_RESET = 16'h0000;
	// ==========================================================
	// live status fields
	localparam int LIVE_FULL = 2;
	localparam int LIVE_EMPTY = 1;
	localparam int LIVE_AVAIL = 0;
	// ==========================================================
	// packet state codes
	localparam logic [2:0] PS_MIDDLE = 3'h0;
	localparam logic [2:0] PS_START = 3'h1;
	localparam logic [2:0] PS_END_GOOD = 3'h4;
	localparam logic [2:0] PS_END_FCS = 3'h5;
	localparam logic [2:0] PS_END_ODD = 3'h6;
	localparam logic [2:0] PS_END_ABORT = 3'h7;
	// ==========================================================
	// fifo geometry
	localparam int FIFO_DEPTH = 256;
	localparam int FIFO_AW = 8;
	localparam int GROUP_SHIFT = 3;
endpackage

// file: hdl/hrxf_skid.sv
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module hrxf_skid #(
	parameter int WIDTH = 11
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	logic [WIDTH-1:0] mem_ff [2];
	logic rd_ff;
	logic wr_ff;
	logic [1:0] cnt_ff;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;

	// handshake flags come straight from the fill count
	assign in_ready = (cnt_ff != 2'h2);
	assign out_valid = (cnt_ff != 2'h0);
	assign out_data = mem_ff[rd_ff];

	// ==========================================================
	// storage and pointers
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			rd_ff <= 1'b0;
			wr_ff <= 1'b0;
			cnt_ff <= 2'h0;
			mem_ff[0] <= '0;
			mem_ff[1] <= '0;
		end else begin
			if (push) begin
				mem_ff[wr_ff] <= in_data;
				wr_ff <= ~wr_ff;
			end
			if (pop)
				rd_ff <= ~rd_ff;
			cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
		end
	end
endmodule // hrxf_skid

// file: hdl/hrxf_fifo.sv
// receive byte fifo with entry count
`timescale 1ns/1ps
module hrxf_fifo #(
	parameter int WIDTH = 11,
	parameter int AW = 8
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic flush,
	input wire logic wr_en,
	input wire logic [WIDTH-1:0] wr_data,
	input wire logic rd_en,
	output logic [WIDTH-1:0] rd_data,
	output logic [AW:0] count,
	output logic overflow
);
	localparam logic [AW:0] DEPTH = (AW+1)'(1 << AW);
	logic [WIDTH-1:0] mem_ff [1 << AW];
	logic [AW-1:0] wp_ff;
	logic [AW-1:0] rp_ff;
	logic [AW:0] cnt_ff;
	wire full = (cnt_ff == DEPTH);
	wire empty = (cnt_ff == '0);
	wire do_wr = wr_en && !full;
	wire do_rd = rd_en && !empty;

	// a write into a full fifo is dropped, and flagged unless a read lands in the same cycle
	assign overflow = wr_en && full && !do_rd;
	assign rd_data = mem_ff[rp_ff];
	assign count = cnt_ff;

	// ==========================================================
	// memory write, kept out of reset to stay a plain array
	always_ff @(posedge clock) begin
		if (do_wr)
			mem_ff[wp_ff] <= wr_data;
	end

	// pointers and count
	always_ff @(posedge clock) begin
		if (!reset_n || flush) begin
			wp_ff <= '0;
			rp_ff <= '0;
			cnt_ff <= '0;
		end else begin
			if (do_wr)
				wp_ff <= wp_ff + 1'b1;
			if (do_rd)
				rp_ff <= rp_ff + 1'b1;
			cnt_ff <= cnt_ff + (AW+1)'(do_wr) - (AW+1)'(do_rd);
		end
	end
endmodule // hrxf_fifo

// file: sim/hrxf_chk.sv
// port checker for the receive fifo read-out
`timescale 1ns/1ps
module hrxf_chk (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic [7:0] host_addr,
	input wire logic host_rd,
	input wire logic host_wr,
	input wire logic [1:0] host_be,
	input wire logic [15:0] host_wdata,
	input wire logic [15:0] host_rdata,
	input wire logic rx_valid,
	input wire logic rx_ready,
	input wire logic [7:0] rx_byte,
	input wire logic [2:0] rx_code,
	input wire logic port_global_irq_en,
	input wire logic irq
);
	// ==========================================================
	// one domain, all checks off while in reset
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);
	// read of one address, and a lower-lane data read
	sequence rd_s(logic [7:0] a);
		host_rd && host_addr == a;
	endsequence
	sequence lo_rd_s;
		rd_s(hrxf_pkg::OFF_DATA) ##0 host_be == 2'h1;
	endsequence
	// ==========================================================
	// interrupt gating
	irq_gate_a: assert property (irq |-> port_global_irq_en)
		else $error("irq without port enable");
	irq_off_a: assert property (
		host_wr && host_addr == hrxf_pkg::OFF_IRQEN && host_be == 2'h3
		&& host_wdata == 16'h0000 |=> !irq) else $error("irq with enables cleared");
	// ==========================================================
	// register contents
	data_rsvd_a: assert property (
		rd_s(hrxf_pkg::OFF_DATA) |=> host_rdata[7:4] == 4'h0) else $error("data bits 7:4 set");
	code_rsvd_a: assert property (
		rd_s(hrxf_pkg::OFF_DATA) |=> !(host_rdata[0] && host_rdata[3:2] == 2'h1))
		else $error("reserved packet code");
	live_excl_a: assert property (
		rd_s(hrxf_pkg::OFF_LIVE) |=> !(host_rdata[2] && host_rdata[1])
		&& host_rdata[15:3] == 13'h0000) else $error("live full with empty");
	avail_empty_a: assert property (
		rd_s(hrxf_pkg::OFF_LIVE) |=> !(host_rdata[1] && host_rdata[0]))
		else $error("available while empty");
	latch_mask_a: assert property (
		rd_s(hrxf_pkg::OFF_LATCH) |=> (host_rdata & ~hrxf_pkg::EVENT_MASK) == 16'h0000)
		else $error("latched bit outside events");
	// a lower-lane read must not pop a shown byte
	lo_read_a: assert property (
		lo_rd_s ##1 lo_rd_s ##0 host_rdata[0] |=> host_rdata == $past(host_rdata))
		else $error("lower read changed data");
endmodule // hrxf_chk

bind hrxf_top hrxf_chk u_chk (.clock, .reset_n, .host_addr, .host_rd, .host_wr, .host_be,
	.host_wdata, .host_rdata, .rx_valid, .rx_ready, .rx_byte, .rx_code, .port_global_irq_en,
	.irq);

// file: sim/test_hdlc_rx_fifo_status_readout.sv
// self-checking bench for the receive fifo read-out
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin errors++; \
	$display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module test_hdlc_rx_fifo_status_readout;
	localparam logic [7:0] CTL = hrxf_pkg::OFF_CTRL;
	localparam logic [7:0] LIV = hrxf_pkg::OFF_LIVE;
	localparam logic [7:0] LAT = hrxf_pkg::OFF_LATCH;
	localparam logic [7:0] IEN = hrxf_pkg::OFF_IRQEN;
	localparam logic [7:0] DAT = hrxf_pkg::OFF_DATA;
	logic clock = 0, reset_n = 0, host_rd = 0, host_wr = 0, rx_valid = 0, rx_ready, irq;
	logic port_global_irq_en = 0, rd_d = 0, reo = 0;
	logic [7:0] host_addr = 0, rx_byte = 0;
	logic [1:0] host_be = 0;
	logic [2:0] rx_code = 0;
	logic [15:0] host_wdata = 0, host_rdata, m, e, r;
	logic [15:0] qe[$], qm[$];
	logic [10:0] eq[$], w;
	int errors = 0, check_count = 0;
	hrxf_top u_dut (.clock, .reset_n, .host_addr, .host_rd, .host_wr, .host_be, .host_wdata,
		.host_rdata, .rx_valid, .rx_ready, .rx_byte, .rx_code, .port_global_irq_en, .irq);
	// ==========================================================
	// clock and result monitor
	initial begin
		forever #2.5 clock = ~clock;
	end
	// read data lands one cycle after the request, judged mid-cycle
	always @(posedge clock) rd_d <= host_rd;
	always @(negedge clock) begin
		if (rd_d) begin
			m = qm.pop_front();
			e = qe.pop_front();
			`CHK(host_rdata & m, e)
		end
	end
	// ==========================================================
	// drivers: each assigns just after an edge, then waits one; send waits until taken, idle waits n
	task automatic rd(input logic [7:0] a, input logic [1:0] b, input logic [15:0] x, y);
		host_addr <= a;
		host_be <= b;
		host_rd <= 1'b1;
		host_wr <= 1'b0;
		rx_valid <= 1'b0;
		qe.push_back(x & y);
		qm.push_back(y);
		@(posedge clock);
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		host_addr <= a;
		host_be <= 2'h3;
		host_wdata <= d;
		host_wr <= 1'b1;
		host_rd <= 1'b0;
		rx_valid <= 1'b0;
		@(posedge clock);
	endtask
	task automatic idle(input int n);
		repeat (n) begin
			host_rd <= 1'b0;
			host_wr <= 1'b0;
			rx_valid <= 1'b0;
			@(posedge clock);
		end
	endtask
	// byte offered until taken; expected order kept in eq
	task automatic send(input logic [2:0] c);
		logic [7:0] b, v;
		b = 8'($urandom);
		v = {<<{b}};
		rx_byte <= b;
		rx_code <= c;
		rx_valid <= 1'b1;
		host_rd <= 1'b0;
		host_wr <= 1'b0;
		eq.push_back({c, reo ? v : b});
		do @(posedge clock); while (rx_ready !== 1'b1);
	endtask
	// status first, twice, then the popping upper read
	task automatic pop();
		w = eq.pop_front();
		rd(DAT, 2'h1, {12'h000, w[10:8], 1'b1}, 16'h00FF);
		rd(DAT, 2'h1, {12'h000, w[10:8], 1'b1}, 16'h00FF);
		rd(DAT, 2'h2, {w[7:0], 8'h00}, 16'hFF00);
		idle(3);
	endtask
	task automatic chk_irq(input logic x);
		idle(1);
		@(negedge clock);
		`CHK(irq, x)
		@(posedge clock);
	endtask
	task automatic finish_test();
		if (errors == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// ==========================================================
	// watchdog, far beyond the few thousand cycles needed
	initial begin
		#200000;
		errors++;
		finish_test();
	end
	// main sequence
	initial begin
		void'($urandom(32'h5362));
		repeat (3) @(posedge clock);
		reset_n <= 1'b1;
		@(posedge clock);
		rd(CTL, 2'h3, hrxf_pkg::CTRL_RESET, 16'hFFFF);
		rd(IEN, 2'h3, hrxf_pkg::IRQEN_RESET, 16'hFFFF);
		rd(LIV, 2'h3, 16'h0002, 16'h0007);
		rd(DAT, 2'h3, 16'h0000, 16'h00F1);
		rd(8'hA0, 2'h3, 16'h0000, 16'hFFFF);
		r = 16'($urandom) & hrxf_pkg::EVENT_MASK;
		wr(IEN, r);
		rd(IEN, 2'h3, r, 16'hFFFF);
		// every end code, both bit orders, port enable off then on
		for (int k = 4; k < 8; k++) begin
			reo = k[0];
			wr(CTL, hrxf_pkg::CTRL_RESET | {12'h000, reo, 3'h0});
			wr(IEN, 16'h0008);
			port_global_irq_en <= k[1];
			send(hrxf_pkg::PS_START);
			send(hrxf_pkg::PS_MIDDLE);
			send(3'(k));
			idle(6);
			chk_irq(k[1]);
			rd(LAT, 2'h3, 16'h0018, 16'h009D);
			rd(LAT, 2'h3, 16'h0018, 16'h009D);
			wr(LAT, 16'hFFFF);
			rd(LAT, 2'h3, 16'h0000, 16'h009D);
			wr(IEN, 16'h0000);
			chk_irq(1'b0);
			repeat (3) pop();
		end
		// fill past full with the receiver stalling, then drain
		reo = 1'b0;
		wr(CTL, hrxf_pkg::CTRL_RESET);
		wr(IEN, 16'h0085);
		repeat (hrxf_pkg::FIFO_DEPTH + 2) send(hrxf_pkg::PS_MIDDLE);
		idle(6);
		chk_irq(1'b1);
		rd(LIV, 2'h3, 16'h0005, 16'h0007);
		rd(LAT, 2'h3, 16'h0085, 16'h009D);
		wr(LAT, 16'hFFFF);
		rd(LAT, 2'h3, 16'h0000, 16'h0005);
		repeat (hrxf_pkg::FIFO_DEPTH + 2) pop();
		rd(LIV, 2'h3, 16'h0002, 16'h0007);
		// both lanes, so the upper lane asks for a pop that must not happen
		rd(DAT, 2'h3, 16'h0000, 16'h00F1);
		send(hrxf_pkg::PS_START);
		idle(6);
		pop();
		// flush with a zero threshold: queued bytes vanish, available held low
		send(hrxf_pkg::PS_START);
		send(hrxf_pkg::PS_MIDDLE);
		idle(6);
		wr(CTL, 16'h0001);
		idle(1);
		rd(LIV, 2'h3, 16'h0002, 16'h0007);
		rd(DAT, 2'h3, 16'h0000, 16'h00F1);
		wr(CTL, hrxf_pkg::CTRL_RESET);
		eq.delete();
		send(hrxf_pkg::PS_END_GOOD);
		idle(6);
		pop();
		idle(2);
		finish_test();
	end
endmodule // test_hdlc_rx_fifo_status_readout
